// File: hw/pbsram_port.sv
// Purpose: Synchronous port and array of a 32K x 36 pipelined burst memory
// Assumes: Far end drives synchronous pins from clk; rst stands in for power-up
// Notes:   Double-cycle deselect; output enable and sleep gate drivers without the clock
//
// Functional notes
// - All synchronous pins are captured in registers on the rising clock edge.
// - New address loads only with a strobe low and all selects active.
// - Array of 32K words, 36 bits, four byte lanes, registered address.
// - Loading an address copies its two low bits into the burst counter.
// - Burst counter steps on each edge in a burst where advance is sampled low and no strobe is taken.
// - Burst order within four words is linear or interleaved.
// - Burst read gives first word two clocks after start, then one each.
// - Global write low writes all four lanes, ignoring lane selects.
// - Otherwise a lane writes only when its select and the qualifier are low.
// - Writes complete internally from registered controls, no further host action.
// - After deselect, drivers stay on one extra clock through a pipelined enable.
// - Processor strobe is ignored while the primary select is high.
// - Primary select active low, second active high, combined with the third.
// - Selects are sampled only when a new address loads, ignored in bursts.
// - Output enable and sleep gate the drivers asynchronously, not registered on the edge.
// - When both strobes are low and the primary select is low, only the processor strobe is acted on.
// - Order strap low selects linear, high or open selects interleaved.
// - Output enable low drives read data; ignored on first read clock after deselect.
// - Third select is active low, sampled with the others at address load.
`timescale 1ns/1ns
`default_nettype none

module pbsram_port
    import pbsram_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [pbsram_pkg::ADDR_W-1:0] address,
    input  wire logic [pbsram_pkg::DATA_W-1:0] data_in,
    output var  logic [pbsram_pkg::DATA_W-1:0] data_out,
    output var  logic                         data_oe_n,
    input  wire logic                         primary_select_n,
    input  wire logic                         expansion_select_high,
    input  wire logic                         expansion_select_low_n,
    input  wire logic                         proc_addr_strobe_n,
    input  wire logic                         ctrl_addr_strobe_n,
    input  wire logic                         burst_step_n,
    input  wire logic [pbsram_pkg::LANES-1:0]  lane_write_select_n,
    input  wire logic                         byte_write_qualifier_n,
    input  wire logic                         all_byte_write_n,
    input  wire logic                         output_enable_n,
    input  wire logic                         sleep_request,
    input  wire logic                         burst_order_strap
);
    import pbsram_pkg::*;

    // Lanes written this cycle
    function automatic logic [LANES-1:0] write_lanes(input pbs_in_t s);
        if (!s.all_n)
            write_lanes = LANES_ALL;
        else if (!s.qual_n)
            write_lanes = ~s.lane_n;
        else
            write_lanes = LANES_NONE;
    endfunction

    // Low address bits for a burst offset from the loaded start
    function automatic logic [CNT_W-1:0] burst_low(input logic [CNT_W-1:0] start,
                                                   input logic [CNT_W-1:0] off,
                                                   input pbs_order_t       order);
        if (order == PBS_ORDER_LINEAR)
            burst_low = start + off;
        else
            burst_low = start ^ off;
    endfunction

    pbs_in_t           in_r;
    pbs_in_t           in_nxt;
    logic [BASE_W-1:0] base_r;
    logic [BASE_W-1:0] base_nxt;
    logic [CNT_W-1:0]  start_r;
    logic [CNT_W-1:0]  start_nxt;
    logic [CNT_W-1:0]  off_r;
    logic [CNT_W-1:0]  off_nxt;
    logic              active_r;
    logic              active_nxt;
    logic              rd_en_r;
    logic              rd_en_nxt;
    logic              dcd_r;
    logic              dcd_nxt;
    logic [DATA_W-1:0] rd_data_r;
    logic              strap_meta_r;
    logic              strap_r;
    logic              sleep_meta_r;
    logic              sleep_r;
    pbs_order_t        order;
    logic              selected;
    logic              take_proc;
    logic              take_ctrl;
    logic              load;
    logic              access;
    logic [ADDR_W-1:0] acc_addr;
    logic [LANES-1:0]  lanes;

    logic [DATA_W-1:0] mem [DEPTH];

    // Strap and sleep come from off-chip and are synchronised first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta_r <= 1'b1;
            strap_r      <= 1'b1;
            sleep_meta_r <= 1'b0;
            sleep_r      <= 1'b0;
        end
        else
        begin
            strap_meta_r <= burst_order_strap;
            strap_r      <= strap_meta_r;
            sleep_meta_r <= sleep_request;
            sleep_r      <= sleep_meta_r;
        end
    end

    assign order = strap_r ? PBS_ORDER_INTERLEAVED : PBS_ORDER_LINEAR;

    always_comb
    begin
        in_nxt            = PBS_IN_IDLE;
        in_nxt.addr       = address;
        in_nxt.wdata      = data_in;
        in_nxt.sel1_n     = primary_select_n;
        in_nxt.sel2       = expansion_select_high;
        in_nxt.sel3_n     = expansion_select_low_n;
        in_nxt.proc_stb_n = proc_addr_strobe_n;
        in_nxt.ctrl_stb_n = ctrl_addr_strobe_n;
        in_nxt.step_n     = burst_step_n;
        in_nxt.lane_n     = lane_write_select_n;
        in_nxt.qual_n     = byte_write_qualifier_n;
        in_nxt.all_n      = all_byte_write_n;
    end

    // Decode of the captured pins
    always_comb
    begin
        selected  = !in_r.sel1_n && in_r.sel2 && !in_r.sel3_n;
        take_proc = !in_r.proc_stb_n && !in_r.sel1_n;
        take_ctrl = !in_r.ctrl_stb_n && !take_proc;
        load      = (take_proc || take_ctrl) && selected && !sleep_r;
        access    = load || (active_r && !take_proc && !take_ctrl && !sleep_r);
        lanes     = access ? write_lanes(in_r) : LANES_NONE;
    end

    // Burst address state; selects matter only on a strobe edge
    always_comb
    begin
        base_nxt   = base_r;
        start_nxt  = start_r;
        off_nxt    = off_r;
        active_nxt = active_r;
        if (take_proc || take_ctrl)
        begin
            active_nxt = load;
            if (load)
            begin
                base_nxt  = in_r.addr[ADDR_W-1:CNT_W];
                start_nxt = in_r.addr[CNT_W-1:0];
                off_nxt   = CNT_ZERO;
            end
        end
        else if (active_r && !in_r.step_n)
            off_nxt = off_r + CNT_ONE;
        // Advance high with no strobe keeps the address
        if (load)
            acc_addr = in_r.addr;
        else if (active_r && !in_r.step_n)
            acc_addr = {base_r, burst_low(start_r, off_r + CNT_ONE, order)};
        else
            acc_addr = {base_r, burst_low(start_r, off_r, order)};
    end

    // Read pipeline enable plus the extra deselect stage
    always_comb
    begin
        rd_en_nxt = access && (lanes == LANES_NONE);
        dcd_nxt   = rd_en_r && !rd_en_nxt;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            in_r     <= PBS_IN_IDLE;
            base_r   <= '0;
            start_r  <= CNT_ZERO;
            off_r    <= CNT_ZERO;
            active_r <= 1'b0;
            rd_en_r  <= 1'b0;
            dcd_r    <= 1'b0;
        end
        else
        begin
            in_r     <= in_nxt;
            base_r   <= base_nxt;
            start_r  <= start_nxt;
            off_r    <= off_nxt;
            active_r <= active_nxt;
            rd_en_r  <= rd_en_nxt;
            dcd_r    <= dcd_nxt;
        end
    end

    // Array write is finished in the edge after capture; nothing more from the host
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (lanes[i])
                mem[acc_addr][i*LANE_W +: LANE_W] <= in_r.wdata[i*LANE_W +: LANE_W];
        end
    end

    // Output register: address captured at edge 1, data out at edge 2, sampled at 3
    always_ff @(posedge clk)
    begin
        if (access)
            rd_data_r <= mem[acc_addr];
    end

    assign data_out = rd_data_r;

    // Drivers follow the async enable and sleep directly, gated by the pipeline.
    // The pipeline enable is low on the first clock out of deselect, so the
    // enable pin alone cannot turn drivers on there.
    assign data_oe_n = !((rd_en_r || dcd_r) && !output_enable_n && !sleep_request);

endmodule

`default_nettype wire

// File: hw/pbsram_pkg.sv
// Purpose: Shared constants and types for the pipelined burst memory port
// Assumes: One 250 MHz clock; far end drives all synchronous pins on it
// Notes:   Word is four 9-bit byte lanes (8 data bits plus parity)
package pbsram_pkg;

    localparam int ADDR_W    = 15;
    localparam int DEPTH     = 32768;
    localparam int LANES     = 4;
    localparam int LANE_W    = 9;
    localparam int DATA_W    = LANES * LANE_W;
    localparam int CNT_W     = 2;
    localparam int BASE_W    = ADDR_W - CNT_W;
    localparam int CLK_NS    = 4;

    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL  = 4'hf;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE    = 2'h1;

    typedef enum logic
    {
        PBS_ORDER_LINEAR,
        PBS_ORDER_INTERLEAVED
    } pbs_order_t;

    // All synchronous pins sampled on the rising edge, captured as one group
    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              sel1_n;
        logic              sel2;
        logic              sel3_n;
        logic              proc_stb_n;
        logic              ctrl_stb_n;
        logic              step_n;
        logic [LANES-1:0]  lane_n;
        logic              qual_n;
        logic              all_n;
    } pbs_in_t;

    localparam pbs_in_t PBS_IN_IDLE = '{
        addr: '0, wdata: '0, sel1_n: 1'b1, sel2: 1'b0, sel3_n: 1'b1,
        proc_stb_n: 1'b1, ctrl_stb_n: 1'b1, step_n: 1'b1,
        lane_n: LANES_ALL, qual_n: 1'b1, all_n: 1'b1};

endpackage

// File: verif/pbs_host.sv
// Purpose: Far-end bus master that drives the memory's synchronous pins
// Assumes: The bench changes requests at the falling edge
// Notes:   Idle data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module pbs_host
(
    input  wire logic                clk,
    input  wire pbsram_pkg::pbs_in_t req,
    output var  pbsram_pkg::pbs_in_t pins
);
    import pbsram_pkg::*;
    logic [DATA_W-1:0] last_r;
    always_comb
    begin
        pins = req; // Advance low steps a burst
        if (req.all_n && req.qual_n)
            pins.wdata = ~last_r;
    end
    always_ff @(posedge clk)
        last_r <= pins.wdata;
endmodule
`default_nettype wire

// File: verif/pbs_props.sv
// Purpose: Bound pin-level checks of the burst memory port
// Assumes: Inputs change away from the rising edge
// Notes:   Drive checks are gated by output enable and sleep
`timescale 1ns/1ns
`default_nettype none
module pbs_props
(
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic [pbsram_pkg::DATA_W-1:0] data_out,
    input wire logic                          data_oe_n,
    input wire logic                          primary_select_n,
    input wire logic                          expansion_select_high,
    input wire logic                          expansion_select_low_n,
    input wire logic                          proc_addr_strobe_n,
    input wire logic                          ctrl_addr_strobe_n,
    input wire logic                          burst_step_n,
    input wire logic [pbsram_pkg::LANES-1:0]  lane_write_select_n,
    input wire logic                          byte_write_qualifier_n,
    input wire logic                          all_byte_write_n,
    input wire logic                          output_enable_n,
    input wire logic                          sleep_request
);
    import pbsram_pkg::*;
    logic ok, wr, stb, rd_ld, desel, step, off;
    assign ok = !primary_select_n && expansion_select_high && !expansion_select_low_n;
    assign wr = !all_byte_write_n || (!byte_write_qualifier_n && lane_write_select_n != LANES_ALL);
    assign stb = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    assign rd_ld = ok && stb && !wr && !sleep_request;
    assign desel = !ok && (!ctrl_addr_strobe_n || (!proc_addr_strobe_n && !primary_select_n));
    assign step = proc_addr_strobe_n && ctrl_addr_strobe_n && !burst_step_n && !wr;
    assign off = output_enable_n || sleep_request;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_oe_gate: assert property (output_enable_n |-> data_oe_n) else $error("drive with oe high");
    a_sleep_gate: assert property (sleep_request |-> data_oe_n) else $error("drive in sleep");
    // Sleep reaches the access logic through two flops, so the edge before the load counts
    a_read_drive: assert property (rd_ld && !$past(sleep_request) |-> ##2 off || !data_oe_n)
        else $error("read not driven");
    a_extra_cycle: assert property ($rose(data_oe_n) && !off && !$past(off) && !$past(off, 2)
        |-> !$past(data_oe_n, 2)) else $error("no extra drive cycle");
    a_desel_hold: assert property (desel |-> ##2 $stable(data_out)) else $error("data moved");
    a_write_quiet: assert property ((ok && stb && !all_byte_write_n) [*3] |=> data_oe_n)
        else $error("drive during writes");
    // Words two to four of the burst stand at the last step edge and the two after it
    a_burst_run: assert property (rd_ld && !$past(sleep_request) ##1 step [*3] |-> (off || !data_oe_n) [*3])
        else $error("burst gap");
    a_reset_off: assert property ($fell(rst) |-> data_oe_n) else $error("drive after reset");
    c_burst: cover property (rd_ld ##1 step [*3]);
    c_write: cover property (ok && stb && !all_byte_write_n);
    c_desel: cover property (desel);
endmodule
bind pbsram_port pbs_props i_props (.clk, .rst, .data_out, .data_oe_n, .primary_select_n, .expansion_select_high,
    .expansion_select_low_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .lane_write_select_n,
    .byte_write_qualifier_n, .all_byte_write_n, .output_enable_n, .sleep_request);
`default_nettype wire

// File: verif/tb.sv
// Purpose: Random and corner tests of the burst memory port
// Assumes: Pins change at the falling edge; fixed seed
// Notes:   Each group is filled before it is read back
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pbsram_pkg::*;
    logic              clk, rst, oe_n, sleep, strap, data_oe_n;
    logic [DATA_W-1:0] data_out, d;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] b;
    pbs_in_t           pin, p;
    int                n_errors, checks_done, cycles, seed;
    pbs_host h (.clk(clk), .req(pin), .pins(p));
    pbsram_port i_dut (.clk(clk), .rst(rst), .address(p.addr), .data_in(p.wdata), .data_out(data_out),
        .data_oe_n(data_oe_n), .primary_select_n(p.sel1_n), .expansion_select_high(p.sel2),
        .expansion_select_low_n(p.sel3_n), .proc_addr_strobe_n(p.proc_stb_n), .ctrl_addr_strobe_n(p.ctrl_stb_n),
        .burst_step_n(p.step_n), .lane_write_select_n(p.lane_n), .byte_write_qualifier_n(p.qual_n),
        .all_byte_write_n(p.all_n), .output_enable_n(oe_n), .sleep_request(sleep), .burst_order_strap(strap));
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 9000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // k: 0 ctrl, 1 proc, 5 both strobes; 2 to 4 are deselects
    function automatic pbs_in_t ld(input logic [ADDR_W-1:0] ad, input int k);
        pbs_in_t v;
        v = PBS_IN_IDLE;
        v.addr = ad;
        v.sel1_n = k == 2;
        v.sel2 = k != 3;
        v.sel3_n = k == 4;
        v.proc_stb_n = !(k inside {1, 2, 5});
        v.ctrl_stb_n = k == 1;
        return v;
    endfunction
    task automatic wr(input logic [ADDR_W-1:0] ad, input int k, input bit g);
        pbs_in_t v;
        v = ld(ad, k);
        v.wdata = DATA_W'({$random(seed), $random(seed)});
        v.lane_n = LANES'($random(seed));
        v.qual_n = 1'($random(seed));
        v.all_n = !g && 1'($random(seed));
        for (int i = 0; i < LANES; i++)
            if (k inside {0, 1, 5} && (!v.all_n || (!v.qual_n && !v.lane_n[i])))
                mem[ad][i*LANE_W +: LANE_W] = v.wdata[i*LANE_W +: LANE_W];
        @(negedge clk);
        pin <= v;
    endtask
    // Word address of burst step c from start ad, in the strapped order
    function automatic logic [ADDR_W-1:0] burst_word(input logic [ADDR_W-1:0] ad, input logic [1:0] c);
        if (strap)
            return {ad[ADDR_W-1:2], ad[1:0] ^ c};
        else
            return {ad[ADDR_W-1:2], ad[1:0] + c};
    endfunction
    task automatic rd(input logic [ADDR_W-1:0] ad, input int len);
        pbs_in_t           v;
        logic [ADDR_W-1:0] q[$];
        logic [1:0]        c;
        v = ld(ad, 1'($random(seed)));
        c = 2'h0;
        for (int i = 0; i < len + 4; i++)
        begin
            @(negedge clk);
            if (i > 1)
                chk("drive", data_oe_n, oe_n | (i > len + 2));
            if (i > 1 && q.size() > 0)
                chk("read", data_out, mem[q.pop_front()]);
            if (i < len)
                q.push_back(burst_word(ad, c));
            pin <= v;
            oe_n <= 1'($random(seed) % 6 == 0);
            v = ld(ad, 2);
            if (i + 1 < len)
            begin
                v.addr = ADDR_W'($random(seed));
                v.sel1_n = 1'($random(seed)); // Ignored inside a burst
                v.proc_stb_n = 1'b1;
                v.ctrl_stb_n = 1'b1;
                v.step_n = 1'($random(seed));
                if (!v.step_n)
                    c++;
            end
        end
    endtask
    initial
    begin
        seed = 32'h9833;
        pin = PBS_IN_IDLE;
        oe_n = 0;
        sleep = 0;
        for (int m = 0; m < 2; m++)
        begin
            rst = 1;
            strap = 1'(m);
            repeat (5) @(negedge clk);
            rst = 0;
            repeat (3) @(negedge clk);
            for (int t = 0; t < 40; t++)
            begin
                b = ADDR_W'($random(seed)) & 15'h7ffc;
                for (int j = 0; j < 4; j++)
                    wr(b + ADDR_W'(j), 0, 1);
                repeat (3) wr(b + ADDR_W'($random(seed) & 3), $unsigned($random(seed)) % 6, 0);
                @(negedge clk);
                pin <= ld(b, 2);
                rd(b | ADDR_W'($random(seed) & 3), 1 + $unsigned($random(seed)) % 6);
            end
        end
        // The last burst has just driven its pins in this time step
        @(negedge clk);
        oe_n <= 0;
        pin <= ld(b, 0);
        @(negedge clk);
        pin <= PBS_IN_IDLE;
        repeat (3) @(negedge clk);
        chk("repeat", data_out, mem[b]);
        chk("repeat drive", data_oe_n, 1'b0);
        sleep = 1;
        #1;
        chk("sleep drive", data_oe_n, 1'b1);
        repeat (3) @(negedge clk);
        d = mem[b];
        wr(b, 0, 1);
        mem[b] = d;
        @(negedge clk);
        pin <= ld(b, 2);
        sleep <= 0;
        repeat (4) @(negedge clk);
        rd(b, 1);
        conclude();
    end
endmodule
`default_nettype wire
